// File: hdl/mbox_pkg.sv
// Constants, codes and types shared by the command mailbox design.
package mbox_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] IDX_CMD     = 16'h4005;
	localparam logic [15:0] IDX_STATUS  = 16'h4037;
	localparam logic [15:0] IDX_PARAM1  = 16'h4038;
	localparam logic [15:0] IDX_PARAM5  = 16'h403c;
	localparam logic [15:0] IDX_CTRL    = 16'h4040;
	localparam int          NUM_PARAMS  = 5;

	// Status word codes.
	localparam logic [15:0] ST_RECEIVED = 16'h0001;
	localparam logic [15:0] ST_IN_PROG  = 16'h0002;
	localparam logic [15:0] ST_PASS     = 16'h0004;
	localparam logic [15:0] ST_ERROR    = 16'h0008;
	localparam logic [15:0] ST_BUSY     = 16'hbbbb;

	// Command codes and fields.
	localparam int          CMD_GO_BIT          = 15;
	localparam logic [15:0] CMD_GET_SWAP        = 16'h8000;
	localparam logic [15:0] CMD_SET_SWAP        = 16'h8001;
	localparam logic [15:0] CMD_GET_TS          = 16'h8004;
	localparam logic [15:0] CMD_SET_TS          = 16'h8005;
	localparam int          CMD_IDX_W           = 6;

	// Values after reset.
	localparam logic [15:0] CMD_RESET    = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0004;
	localparam logic [15:0] PARAM_RESET  = 16'h0000;
	localparam logic [7:0]  SWAP_RESET   = 8'he4;
	localparam logic        TS_RESET     = 1'b0;

	// Control register fields.
	localparam int          CTRL_EVEN_BIT  = 0;
	localparam int          CTRL_TRAIN_BIT = 1;
	localparam int          CTRL_TS_BIT    = 2;

	typedef enum logic [2:0] {
		RT_NONE     = 3'h0,
		RT_GET_SWAP = 3'h1,
		RT_SET_SWAP = 3'h2,
		RT_GET_TS   = 3'h3,
		RT_SET_TS   = 3'h4
	} routine_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_RECV = 2'b01,
		S_PROG = 2'b11
	} state_t;

endpackage

// File: hdl/cmd_dispatch_rom.sv
// Dispatch table mapping a command index to the routine that serves it.
`timescale 1ns/1ps
module cmd_dispatch_rom (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	input  wire logic [mbox_pkg::CMD_IDX_W-1:0]   idx,
	output mbox_pkg::routine_t                    routine_q
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			routine_q <= mbox_pkg::RT_NONE;
		end else begin
			unique case (idx)
				6'h00:   routine_q <= mbox_pkg::RT_GET_SWAP;
				6'h01:   routine_q <= mbox_pkg::RT_SET_SWAP;
				6'h04:   routine_q <= mbox_pkg::RT_GET_TS;
				6'h05:   routine_q <= mbox_pkg::RT_SET_TS;
				default: routine_q <= mbox_pkg::RT_NONE;
			endcase
		end
	end

endmodule

// File: hdl/mdio_command_mailbox.sv
// Command mailbox: APB register file, command sequencer and lane swap / timestamp settings.
//
// Overview of operation
// - After reset the status reads completed-pass and the command word reads zero.
// - A command write with bit 15 set while idle marks it received and schedules it.
// - The command value indexes a dispatch table that selects the serving routine.
// - Starting a dispatched command sets the status to in-progress.
// - On finishing, status becomes completed-pass or completed-error, ready for more.
// - During link training the status word may stay unchanged.
// - Get-swap returns requested swap in word 1 and active swap in word 2.
// - Set-swap takes word 2, applies after auto-negotiation, returns nothing.
// - Odd ports: lane D at 7:6 down to A at 1:0, codes select A..D.
// - Even ports: lane A at 7:6 down to D at 1:0, codes select D..A.
// - Get-timestamp-enable returns the stored enable in word 1.
// - Set-timestamp-enable takes word 1, 1 enables, 0 disables, applies after negotiation.
// - Status codes are 1 received, 2 in progress, 4 pass, 8 error, bbbb busy.
// - Command, status and parameter words sit at their fixed register indices.
// - The status word is writable by the host as well as the device.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mdio_command_mailbox (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [17:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_training,
	input  wire logic        autoneg_done,
	output logic      [7:0]  lane_swap_active,
	output logic      [7:0]  lane_pair_sel,
	output logic             timestamp_enable
);

	logic [15:0]          cmd_q;
	logic [15:0]          status_q;
	logic [15:0]          param_q [mbox_pkg::NUM_PARAMS];
	logic                 even_port_q;
	logic [7:0]           swap_req_q;
	logic [7:0]           swap_act_q;
	logic                 ts_req_q;
	logic                 ts_act_q;
	logic [31:0]          prdata_q;
	logic                 boot_q;
	mbox_pkg::state_t     state_q;
	mbox_pkg::routine_t   routine_q;
	logic [1:0]           train_sync_q;
	logic [1:0]           an_sync_q;
	logic                 train_q;
	logic                 an_q;

	// Decode; every access is zero-wait.
	wire [15:0] idx        = paddr[17:2];
	wire        aligned    = (paddr[1:0] == 2'b00);
	wire        hit_cmd    = aligned && (idx == mbox_pkg::IDX_CMD);
	wire        hit_status = aligned && (idx == mbox_pkg::IDX_STATUS);
	wire        hit_param  = aligned && (idx >= mbox_pkg::IDX_PARAM1) && (idx <= mbox_pkg::IDX_PARAM5);
	wire        hit_ctrl   = aligned && (idx == mbox_pkg::IDX_CTRL);
	wire        mapped     = hit_cmd || hit_status || hit_param || hit_ctrl;
	wire [2:0]  pidx       = 3'(idx - mbox_pkg::IDX_PARAM1);
	wire        setup      = psel && !penable;
	wire        wr         = psel && penable && pwrite && mapped;
	wire        cmd_wr     = wr && hit_cmd;
	wire        status_wr  = wr && hit_status;
	wire        cmd_go     = cmd_wr && pwdata[mbox_pkg::CMD_GO_BIT] && (state_q == mbox_pkg::S_IDLE);
	wire        train_s    = train_sync_q[1];
	wire        train_rise = train_s && !train_q;
	wire        train_fall = !train_s && train_q;
	wire        an_event   = an_sync_q[1] && !an_q;
	wire        cmd_known  = (cmd_q[14:mbox_pkg::CMD_IDX_W] == '0);
	wire        run        = (state_q == mbox_pkg::S_PROG);
	wire        ts_ok      = (param_q[0][15:1] == 15'h0000);

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;

	assign lane_swap_active = swap_act_q;
	assign timestamp_enable = ts_act_q;

	// Lane to pair index, normalised so 0 is pair A; the field order depends on port parity.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			wire [1:0] odd_f  = swap_act_q[2*g+1 -: 2];
			wire [1:0] even_f = swap_act_q[7-2*g -: 2];
			assign lane_pair_sel[2*g+1 -: 2] = even_port_q ? ~even_f : odd_f;
		end
	endgenerate

	wire [31:0] rd_mux = hit_cmd    ? {16'h0000, cmd_q} :
	                     hit_status ? {16'h0000, status_q} :
	                     hit_param  ? {16'h0000, param_q[pidx]} :
	                     hit_ctrl   ? {29'h0, ts_act_q, train_s, even_port_q} : 32'h0;

	cmd_dispatch_rom u_rom (
		.pclk      (pclk),
		.presetn   (presetn),
		.idx       (cmd_q[mbox_pkg::CMD_IDX_W-1:0]),
		.routine_q (routine_q)
	);

	// Pins from outside pass two flip-flops before anything looks at them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			train_sync_q <= 2'b00;
			an_sync_q    <= 2'b00;
			train_q      <= 1'b0;
			an_q         <= 1'b0;
			boot_q       <= 1'b0;
			prdata_q     <= 32'h0;
		end else begin
			train_sync_q <= {train_sync_q[0], link_training};
			an_sync_q    <= {an_sync_q[0], autoneg_done};
			train_q      <= train_s;
			an_q         <= an_sync_q[1];
			boot_q       <= 1'b1;
			if (setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q       <= mbox_pkg::CMD_RESET;
			even_port_q <= 1'b0;
		end else begin
			if (cmd_wr && state_q == mbox_pkg::S_IDLE) begin
				cmd_q <= pwdata[15:0];
			end
			if (wr && hit_ctrl) begin
				even_port_q <= pwdata[mbox_pkg::CTRL_EVEN_BIT];
			end
		end
	end

	// Sequencer; a command waits in received while training, so only a host write changes status then.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= mbox_pkg::S_IDLE;
		end else begin
			unique case (state_q)
				mbox_pkg::S_IDLE: begin
					if (cmd_go) begin
						state_q <= mbox_pkg::S_RECV;
					end
				end
				mbox_pkg::S_RECV: begin
					if (!train_s) begin
						state_q <= mbox_pkg::S_PROG;
					end
				end
				mbox_pkg::S_PROG: begin
					state_q <= mbox_pkg::S_IDLE;
				end
				default: state_q <= mbox_pkg::S_IDLE;
			endcase
		end
	end

	// Device updates win over a host write to the status word in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= mbox_pkg::STATUS_RESET;
		end else if (cmd_go) begin
			status_q <= mbox_pkg::ST_RECEIVED;
		end else if (state_q == mbox_pkg::S_RECV && !train_s) begin
			status_q <= mbox_pkg::ST_IN_PROG;
		end else if (run) begin
			status_q <= (routine_q == mbox_pkg::RT_NONE || !cmd_known ||
			             (routine_q == mbox_pkg::RT_SET_TS && !ts_ok)) ? mbox_pkg::ST_ERROR : mbox_pkg::ST_PASS;
		end else if (state_q == mbox_pkg::S_IDLE && train_rise) begin
			status_q <= mbox_pkg::ST_BUSY;
		end else if (state_q == mbox_pkg::S_IDLE && train_fall && status_q == mbox_pkg::ST_BUSY) begin
			status_q <= mbox_pkg::ST_PASS;
		end else if (status_wr) begin
			status_q <= pwdata[15:0];
		end
	end

	generate
		for (g = 0; g < mbox_pkg::NUM_PARAMS; g++) begin : g_param
			wire dev_wr = run && cmd_known && ((g == 0 && (routine_q == mbox_pkg::RT_GET_SWAP ||
			              routine_q == mbox_pkg::RT_GET_TS)) || (g == 1 && routine_q == mbox_pkg::RT_GET_SWAP));
			wire [15:0] dev_val = (g == 1) ? {8'h00, swap_act_q} :
			                      (routine_q == mbox_pkg::RT_GET_TS) ? {15'h0000, ts_req_q} : {8'h00, swap_req_q};
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					param_q[g] <= mbox_pkg::PARAM_RESET;
				end else if (dev_wr) begin
					param_q[g] <= dev_val;
				end else if (wr && hit_param && pidx == 3'(g)) begin
					param_q[g] <= pwdata[15:0];
				end
			end
		end
	endgenerate

	// Requested settings take effect only when a negotiation completes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swap_req_q <= mbox_pkg::SWAP_RESET;
			swap_act_q <= mbox_pkg::SWAP_RESET;
			ts_req_q   <= mbox_pkg::TS_RESET;
			ts_act_q   <= mbox_pkg::TS_RESET;
		end else begin
			if (run && cmd_known && routine_q == mbox_pkg::RT_SET_SWAP) begin
				swap_req_q <= param_q[1][7:0];
			end
			if (run && cmd_known && routine_q == mbox_pkg::RT_SET_TS && ts_ok) begin
				ts_req_q <= param_q[0][0];
			end
			if (an_event) begin
				swap_act_q <= swap_req_q;
				ts_act_q   <= ts_req_q;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	boot_defaults_a: assert property (!boot_q |-> status_q == 16'h0004 && cmd_q == 16'h0000)
		else $error("status or command wrong after reset");
	cmd_received_a: assert property (cmd_go |=> status_q == 16'h0001 && state_q == mbox_pkg::S_RECV)
		else $error("command not marked received");
	dispatch_pick_a: assert property (run && cmd_q == 16'h8004 |-> routine_q == mbox_pkg::RT_GET_TS)
		else $error("dispatch table chose the wrong routine");
	in_progress_a: assert property (state_q == mbox_pkg::S_RECV && !train_s |=> status_q == 16'h0002 ##1
		(status_q == 16'h0004 || status_q == 16'h0008))
		else $error("in-progress not followed by completion");
	done_code_a: assert property (run && routine_q == mbox_pkg::RT_NONE |=> status_q == 16'h0008)
		else $error("unknown command did not fail");
	train_hold_a: assert property (state_q == mbox_pkg::S_RECV && train_s && !status_wr |=> $stable(status_q))
		else $error("status changed during training");
	get_swap_a: assert property (run && cmd_known && routine_q == mbox_pkg::RT_GET_SWAP |=>
		param_q[0] == {8'h00, $past(swap_req_q)} && param_q[1] == {8'h00, $past(swap_act_q)})
		else $error("swap results wrong");
	swap_apply_a: assert property (an_event |=> swap_act_q == $past(swap_req_q) && ts_act_q == $past(ts_req_q))
		else $error("setting not applied at negotiation");
	swap_defer_a: assert property (!an_event |=> $stable(swap_act_q) && $stable(ts_act_q))
		else $error("setting applied without negotiation");
	even_lane_a: assert property (even_port_q |-> lane_pair_sel[1:0] == ~swap_act_q[7:6])
		else $error("even port lane decode wrong");
	ts_get_a: assert property (run && cmd_known && routine_q == mbox_pkg::RT_GET_TS |=>
		param_q[0] == {15'h0000, $past(ts_req_q)})
		else $error("timestamp enable result wrong");
	noop_write_a: assert property (cmd_wr && pwdata[15:0] == 16'h0000 && state_q == mbox_pkg::S_IDLE &&
		!train_rise && !train_fall |=> $stable(status_q))
		else $error("zero command changed status");

	// Lane decode for both port parities.
	odd_lane_a: assert property (!even_port_q |-> lane_pair_sel == swap_act_q)
		else $error("odd port lane decode wrong");
	even_lane_d_a: assert property (even_port_q |-> lane_pair_sel[7:6] == ~swap_act_q[1:0])
		else $error("even port lane D decode wrong");

	// Stored settings and results of the served commands; the set commands return nothing.
	set_swap_a: assert property (run && cmd_known && routine_q == mbox_pkg::RT_SET_SWAP |=>
		swap_req_q == $past(param_q[1][7:0]))
		else $error("requested swap not stored");
	set_ts_a: assert property (run && cmd_known && routine_q == mbox_pkg::RT_SET_TS && ts_ok |=>
		ts_req_q == $past(param_q[0][0]))
		else $error("requested timestamp enable not stored");
	ts_reject_a: assert property (run && cmd_known && routine_q == mbox_pkg::RT_SET_TS && !ts_ok |=>
		status_q == 16'h0008 && $stable(ts_req_q))
		else $error("bad timestamp enable value accepted");
	set_quiet_a: assert property (run && cmd_known && !wr && (routine_q == mbox_pkg::RT_SET_SWAP ||
		routine_q == mbox_pkg::RT_SET_TS) |=> $stable(param_q[0]) && $stable(param_q[1]))
		else $error("set command changed result words");
	unknown_err_a: assert property (run && !cmd_known |=> status_q == 16'h0008)
		else $error("malformed command did not fail");
	prog_one_a: assert property (run |=> state_q == mbox_pkg::S_IDLE)
		else $error("sequencer did not return to idle");

	// Status and command word ownership between sequencer, training and host; unmapped reads return zero.
	busy_code_a: assert property (state_q == mbox_pkg::S_IDLE && train_rise && !cmd_go |=>
		status_q == 16'hbbbb)
		else $error("training did not report busy");
	status_write_a: assert property (status_wr && state_q == mbox_pkg::S_IDLE && !train_rise && !train_fall |=>
		status_q == $past(pwdata[15:0]))
		else $error("host status write lost");
	recv_hold_a: assert property (state_q == mbox_pkg::S_RECV && train_s |=> state_q == mbox_pkg::S_RECV)
		else $error("command started during training");
	cmd_ignore_a: assert property (cmd_wr && state_q != mbox_pkg::S_IDLE |=> $stable(cmd_q))
		else $error("command word changed while busy");
	cmd_store_a: assert property (cmd_wr && state_q == mbox_pkg::S_IDLE |=> cmd_q == $past(pwdata[15:0]))
		else $error("command word write lost");
	unmapped_zero_a: assert property (setup && !mapped |=> prdata == 32'h0)
		else $error("unmapped read returned data");

endmodule

// File: test/link_side_model.sv
// Link side stand-in: training level and negotiation events timed by a 200 ns link clock.
`timescale 1ns/1ps
module link_side_model (
	input  wire logic train_req,
	input  wire logic neg_req,
	output logic      link_training,
	output logic      autoneg_done
);
	logic link_clk;

	// The link clock is unrelated in phase to pclk, so the block's synchronisers see real crossings.
	initial begin
		link_clk = 1'b0;
		#37;
		forever #100 link_clk = ~link_clk;
	end

	always @(posedge link_clk) begin
		link_training <= train_req;
		autoneg_done <= neg_req;
	end
endmodule

// File: test/tb_mdio_command_mailbox.sv
// Self-checking bench for the command mailbox, driven over APB beside a link side stand-in.
`timescale 1ns/1ps
module tb_mdio_command_mailbox;
	logic        pclk;
	logic        presetn;
	logic [17:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        link_training;
	logic        autoneg_done;
	logic [7:0]  lane_swap_active;
	logic [7:0]  lane_pair_sel;
	logic        timestamp_enable;
	logic        train_req;
	logic        neg_req;
	logic [31:0] rdv;
	logic        errv;
	int          err_count;
	int          checked;

	mdio_command_mailbox dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .link_training, .autoneg_done, .lane_swap_active, .lane_pair_sel, .timestamp_enable);
	link_side_model link_u (.train_req, .neg_req, .link_training, .autoneg_done);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		check({31'h0, pready}, 32'h1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(rdv, exp);
	endtask

	// The host polls until the wanted code shows; the gap between polls is a scaled-down poll period.
	task automatic poll_for(input logic [15:0] exp);
		int n;
		n = 0;
		apb(1'b0, 16'h4037, 32'h0);
		while (rdv !== {16'h0, exp} && n < 60) begin
			n++;
			repeat (4) @(posedge pclk);
			apb(1'b0, 16'h4037, 32'h0);
		end
		check(rdv, {16'h0, exp});
	endtask

	task automatic issue(input logic [15:0] code, input logic [15:0] fin);
		int n;
		n = 0;
		apb(1'b0, 16'h4037, 32'h0);
		while ((rdv[15:0] === mbox_pkg::ST_IN_PROG || rdv[15:0] === mbox_pkg::ST_BUSY) && n < 60) begin
			n++;
			apb(1'b0, 16'h4037, 32'h0);
		end
		check({31'h0, (n < 60)}, 32'h1);
		apb(1'b1, 16'h4005, {16'h0, code});
		poll_for(fin);
	endtask

	task automatic negotiate;
		neg_req <= 1'b1;
		repeat (40) @(posedge pclk);
		neg_req <= 1'b0;
		repeat (40) @(posedge pclk);
	endtask

	function automatic logic [7:0] pair_map(input logic [7:0] w, input logic even);
		logic [7:0] s;
		for (int i = 0; i < 4; i++) begin
			s[2*i +: 2] = even ? 2'd3 - w[6-2*i +: 2] : w[2*i +: 2];
		end
		return s;
	endfunction

	task automatic t_reset;
		rd_chk(16'h4037, 32'h4);
		rd_chk(16'h4005, 32'h0);
		for (int i = 0; i < mbox_pkg::NUM_PARAMS; i++) begin
			rd_chk(16'h4038 + 16'(i), 32'h0);
		end
		check({24'h0, lane_swap_active}, 32'he4);
		check({31'h0, timestamp_enable}, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_busy;
		train_req <= 1'b1;
		poll_for(16'hbbbb);
		apb(1'b1, 16'h4037, 32'h4);
		rd_chk(16'h4037, 32'h4);
		apb(1'b1, 16'h4005, 32'h8004);
		repeat (3) rd_chk(16'h4037, 32'h1);
		apb(1'b1, 16'h4005, 32'h8001);
		rd_chk(16'h4005, 32'h8004);
		train_req <= 1'b0;
		poll_for(16'h4);
		rd_chk(16'h4038, 32'h0);
		$display("busy test done");
	endtask

	task automatic t_swap;
		apb(1'b1, 16'h4039, 32'hab9c);
		issue(16'h8001, 16'h4);
		check({24'h0, lane_swap_active}, 32'he4);
		issue(16'h8000, 16'h4);
		rd_chk(16'h4038, 32'h9c);
		rd_chk(16'h4039, 32'he4);
		negotiate();
		check({24'h0, lane_swap_active}, 32'h9c);
		check({24'h0, lane_pair_sel}, {24'h0, pair_map(8'h9c, 1'b0)});
		apb(1'b1, mbox_pkg::IDX_CTRL, 32'h1);
		check({24'h0, lane_pair_sel}, {24'h0, pair_map(8'h9c, 1'b1)});
		issue(16'h8000, 16'h4);
		rd_chk(16'h4039, 32'h9c);
		$display("swap test done");
	endtask

	task automatic t_stamp;
		apb(1'b1, 16'h4038, 32'h1);
		issue(16'h8005, 16'h4);
		check({31'h0, timestamp_enable}, 32'h0);
		issue(16'h8004, 16'h4);
		rd_chk(16'h4038, 32'h1);
		negotiate();
		check({31'h0, timestamp_enable}, 32'h1);
		rd_chk(mbox_pkg::IDX_CTRL, 32'h5);
		apb(1'b1, 16'h4038, 32'h2);
		issue(16'h8005, 16'h8);
		check({31'h0, timestamp_enable}, 32'h1);
		issue(16'h8002, 16'h8);
		$display("stamp test done");
	endtask

	task automatic t_misc;
		apb(1'b1, 16'h4005, 32'h0);
		rd_chk(16'h4037, 32'h8);
		apb(1'b1, 16'h4005, 32'h5);
		rd_chk(16'h4005, 32'h5);
		rd_chk(16'h4037, 32'h8);
		apb(1'b0, 16'h4041, 32'h0);
		check({31'h0, errv}, 32'h1);
		check(rdv, 32'h0);
		issue(16'h8040, 16'h8);
		$display("misc test done");
	endtask

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		paddr = 18'h0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		train_req = 1'b0;
		neg_req = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_busy();
		t_swap();
		t_stamp();
		t_misc();
		print_verdict();
	end

	// The tests need a few hundred cycles; this margin only trips on a hang.
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		print_verdict();
	end
endmodule
